// ---- core/sar8_conversion_control.sv ----
// Conversion control for the 8-bit SAR converter subsystem
`timescale 1ns/1ps
`include "sar8_map.svh"
module sar8_conversion_control (
  input wire logic clk,
  input wire logic rstn,
  input wire logic converter_on,
  input wire logic low_power_track_sel,
  input wire logic [2:0] start_source_sel,
  input wire logic [4:0] clock_divide_field,
  input wire logic [1:0] gain_code,
  input wire logic [2:0] channel_select,
  input wire logic busy_write_one,
  input wire logic partner_conv_go,
  input wire logic timer3_overflow,
  input wire logic timer2_overflow,
  input wire logic ext_convert_strobe,
  input wire logic chip_standby,
  input wire logic done_flag_clear,
  input wire logic interrupt_enable,
  input wire logic sar_compare,
  output logic conv_in_progress,
  output logic conv_done_flag,
  output logic irq,
  output logic [7:0] result_byte,
  output sar8_pkg::analog_ctrl_t analog_ctrl,
  output logic sar_clk_en,
  output sar8_pkg::result_t result_data,
  output logic result_valid,
  input wire logic result_ready
);
  import sar8_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Local constants

  // Last phase of each stage, kept at the phase counter's width
  localparam logic [`SAR8_PHASE_W-1:0] TRACK_LAST = `SAR8_LP_TRACK_CLOCKS - 4'h1;
  localparam logic [`SAR8_PHASE_W-1:0] CONV_LAST = `SAR8_CONV_CLOCKS - 4'h1;
  localparam logic [`SAR8_DATA_W-1:0] TRIAL_FIRST = `SAR8_TRIAL_FIRST;

  ////////////////////////////////////////////////////////////////////////////
  // State

  conv_state_t state;
  conv_state_t next_state;
  logic [`SAR8_DIV_W-1:0] div_count;
  logic [`SAR8_PHASE_W-1:0] phase_count;
  logic [`SAR8_DATA_W-1:0] sar_reg;
  logic [`SAR8_DATA_W-1:0] next_sar;
  logic [2:0] held_channel;
  logic [1:0] held_gain;
  logic [1:0] gain_reg;
  logic strobe_prev;
  logic busy_prev;
  logic fifo_ready;
  result_t fifo_in;

  ////////////////////////////////////////////////////////////////////////////
  // SAR clock divider

  wire div_wrap = (div_count == clock_divide_field);
  // no SAR clock while shut down
  wire sar_tick = converter_on && div_wrap;

  // Held at zero while off, so the first tick after enable is a full period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_count <= '0;
    end else if (!converter_on || div_wrap) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  assign sar_clk_en = sar_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Start source selection

  // Inputs are synchronous, so one flop is enough for edge detection
  wire strobe_rise = ext_convert_strobe && !strobe_prev;
  // one decoded source at a time
  wire sel_software = (start_source_sel == `SAR8_SRC_SOFTWARE);
  wire sel_timer3 = (start_source_sel == `SAR8_SRC_TIMER3);
  wire sel_strobe = (start_source_sel == `SAR8_SRC_STROBE);
  wire sel_timer2 = (start_source_sel == `SAR8_SRC_TIMER2);
  wire sel_partner = start_source_sel[`SAR8_SRC_PARTNER_BIT];

  wire start_software = sel_software && busy_write_one;
  wire start_timer = (sel_timer3 && timer3_overflow) || (sel_timer2 && timer2_overflow);
  wire start_strobe = sel_strobe && strobe_rise;
  wire start_partner = sel_partner && partner_conv_go;
  wire start_event = start_software || start_timer || start_strobe || start_partner;

  // ignore starts while busy
  // A full result queue also holds off starts, so no result is ever dropped
  wire start_accept = converter_on && (state == ST_IDLE) && start_event && fifo_ready;

  // strobe in low power skips the fixed track interval
  wire skip_track = !low_power_track_sel || sel_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  wire track_done = sar_tick && (phase_count == TRACK_LAST);
  wire conv_finish = (state == ST_CONVERT) && sar_tick && (phase_count == CONV_LAST);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_accept) begin
          next_state = skip_track ? ST_CONVERT : ST_TRACK;
        end
      end
      ST_TRACK: begin
        if (track_done) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_finish) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!converter_on) begin
      next_state = ST_IDLE;
    end
  end

  wire state_change = (next_state != state);
  wire enter_convert = state_change && (next_state == ST_CONVERT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_count <= '0;
    end else if (state_change) begin
      phase_count <= '0;
    end else if (sar_tick && (state != ST_IDLE)) begin
      phase_count <= phase_count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation

  // Bit under trial runs from the top bit downward, one per SAR clock
  wire trial_step = (state == ST_CONVERT) && sar_tick && (phase_count < `SAR8_TRIAL_CLOCKS);
  wire [2:0] bit_idx = 3'h7 - phase_count[2:0];

  genvar i;
  generate
    for (i = 0; i < `SAR8_DATA_W; i++) begin : g_sar_bit
      wire is_trial = (bit_idx == 3'(i));
      wire is_next = (bit_idx != 3'h0) && (3'(i) == bit_idx - 3'h1);
      wire first_bit = TRIAL_FIRST[i];
      // Each trial settles its own bit and, above bit 0, raises the one below it for the next trial
      assign next_sar[i] = enter_convert ? first_bit :
                           !trial_step ? sar_reg[i] :
                           is_trial ? sar_compare :
                           is_next ? 1'b1 : sar_reg[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sar_reg <= '0;
    end else begin
      sar_reg <= next_sar;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_reg <= `SAR8_GAIN_RESET;
    end else begin
      // One cycle behind gain_code; the value at start is the one the result reports
      // gain follows software setting
      gain_reg <= gain_code;
    end
  end

  // Channel and gain are frozen at start for the result only; the analog selects follow channel_select and gain_reg live
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      held_channel <= '0;
      held_gain <= `SAR8_GAIN_RESET;
    end else if (start_accept) begin
      held_channel <= channel_select;
      held_gain <= gain_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy, done flag and result

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_prev <= 1'b0;
      busy_prev <= 1'b0;
    end else begin
      strobe_prev <= ext_convert_strobe;
      busy_prev <= conv_in_progress;
    end
  end

  assign conv_in_progress = (state != ST_IDLE);

  // A shutdown in mid-conversion drops busy too, so the flag is set with no new result
  // set on busy falling edge
  wire busy_fall = busy_prev && !conv_in_progress;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_done_flag <= 1'b0;
    end else if (busy_fall) begin
      conv_done_flag <= 1'b1;
    end else if (done_flag_clear) begin
      conv_done_flag <= 1'b0;
    end
  end

  assign irq = conv_done_flag && interrupt_enable;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_byte <= `SAR8_RESULT_RESET;
    end else if (conv_finish) begin
      // Same edge as the queue push, so both carry the final code
      // result on completion
      result_byte <= sar_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls

  wire lp_strobe_track = low_power_track_sel && sel_strobe && !ext_convert_strobe;
  wire idle_track = (state == ST_IDLE) && (!low_power_track_sel || lp_strobe_track);
  wire track_on = converter_on && !chip_standby && (idle_track || (state == ST_TRACK));

  // power gate for the analog parts
  assign analog_ctrl.powered = converter_on;
  assign analog_ctrl.track = track_on;
  assign analog_ctrl.channel_onehot = converter_on ? (8'h01 << channel_select) : 8'h00;
  assign analog_ctrl.gain_onehot = converter_on ? (4'h1 << gain_reg) : 4'h0;
  assign analog_ctrl.trial_code = sar_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Result queue

  // Pushes only follow an accepted start, and starts wait for room, so none is lost
  assign fifo_in.channel = held_channel;
  assign fifo_in.gain = held_gain;
  assign fifo_in.data = sar_reg;

  sample_fifo #(
    .WIDTH($bits(result_t)),
    .DEPTH(`SAR8_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data(fifo_in),
    .in_valid(conv_finish),
    .in_ready(fifo_ready),
    .out_data(result_data),
    .out_valid(result_valid),
    .out_ready(result_ready)
  );

endmodule : sar8_conversion_control

// ---- common/sar8_map.svh ----
// Constants for the 8-bit SAR conversion control block
`ifndef SAR8_MAP_SVH
`define SAR8_MAP_SVH

`define SAR8_DATA_W 8
`define SAR8_DIV_W 5
`define SAR8_PHASE_W 4
`define SAR8_FIFO_DEPTH 32

`define SAR8_GAIN_RESET 2'h0
`define SAR8_RESULT_RESET 8'h00
`define SAR8_TRIAL_FIRST 8'h80

`define SAR8_SRC_SOFTWARE 3'h0
`define SAR8_SRC_TIMER3 3'h1
`define SAR8_SRC_STROBE 3'h2
`define SAR8_SRC_TIMER2 3'h3
`define SAR8_SRC_PARTNER_BIT 2

`define SAR8_LP_TRACK_CLOCKS 4'h3
`define SAR8_TRIAL_CLOCKS 4'h8
`define SAR8_CONV_CLOCKS 4'hA

`endif

// ---- common/sar8_pkg.sv ----
// Types shared by the SAR conversion control block
package sar8_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TRACK = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_t;

  typedef struct packed {
    logic [2:0] channel;
    logic [1:0] gain;
    logic [7:0] data;
  } result_t;

  typedef struct packed {
    logic powered;
    logic track;
    logic [7:0] channel_onehot;
    logic [3:0] gain_onehot;
    logic [7:0] trial_code;
  } analog_ctrl_t;

endpackage : sar8_pkg

// ---- core/sample_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Extra pointer bit tells full from empty
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : sample_fifo

// ---- tb/sar8_conversion_control_monitor.sv ----
// Port-level assertions for the SAR conversion control block
`timescale 1ns/1ps
module sar8_conversion_control_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic converter_on,
  input wire logic [2:0] start_source_sel,
  input wire logic [4:0] clock_divide_field,
  input wire logic busy_write_one,
  input wire logic partner_conv_go,
  input wire logic timer3_overflow,
  input wire logic timer2_overflow,
  input wire logic ext_convert_strobe,
  input wire logic done_flag_clear,
  input wire logic interrupt_enable,
  input wire logic conv_in_progress,
  input wire logic conv_done_flag,
  input wire logic irq,
  input wire logic sar_clk_en,
  input wire logic result_valid
);
  logic strobe_q;
  logic seen;
  logic [5:0] gap;
  wire go = (start_source_sel == 3'h0 && busy_write_one) || (start_source_sel == 3'h1 && timer3_overflow)
    || (start_source_sel == 3'h2 && ext_convert_strobe && !strobe_q)
    || (start_source_sel == 3'h3 && timer2_overflow) || (start_source_sel[2] && partner_conv_go);
  ////////////////////////////////////////////////////////////////////////////////
  // Gap is only trusted once a tick has been seen since the divider last restarted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= 1'b0;
      seen <= 1'b0;
      gap <= 6'h00;
    end else begin
      strobe_q <= ext_convert_strobe;
      seen <= converter_on && (seen || sar_clk_en);
      gap <= (sar_clk_en || !converter_on) ? 6'h01 : gap + 6'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  chk_irq_mirror: assert property (irq == (conv_done_flag && interrupt_enable))
    else $error("irq differs from flag and enable");
  chk_start_taken: assert property (go && converter_on && !conv_in_progress && !result_valid |=> conv_in_progress)
    else $error("selected start event did not start a conversion");
  chk_other_ignored: assert property (!go && !conv_in_progress |=> !conv_in_progress)
    else $error("conversion started without the selected event");
  chk_busy_holds: assert property ($rose(conv_in_progress) |-> conv_in_progress [*8])
    else $error("busy dropped too early");
  chk_flag_on_fall: assert property ($fell(conv_in_progress) |=> conv_done_flag)
    else $error("done flag not set after busy fell");
  chk_flag_sticky: assert property (conv_done_flag && !done_flag_clear |=> conv_done_flag)
    else $error("done flag cleared by itself");
  chk_flag_clear: assert property (done_flag_clear && !$fell(conv_in_progress) |=> !conv_done_flag)
    else $error("done flag not cleared");
  chk_tick_period: assert property (sar_clk_en && seen |-> gap == {1'b0, clock_divide_field} + 6'h01)
    else $error("sar clock period wrong");
endmodule : sar8_conversion_control_monitor

// ---- tb/sar8_comparator_model.sv ----
// Behavioural comparator standing behind the SAR trial code
`timescale 1ns/1ps
module sar8_comparator_model (
  input wire logic clk,
  input wire sar8_pkg::analog_ctrl_t analog_ctrl,
  input wire logic [7:0] level,
  output logic sar_compare
);
  logic wobble = 1'b0;
  always @(posedge clk) wobble <= ~wobble;
  // An unpowered comparator says nothing useful, so its output wanders
  assign sar_compare = analog_ctrl.powered ? (level >= analog_ctrl.trial_code) : wobble;
endmodule : sar8_comparator_model

// ---- tb/sar8_conversion_control_tb.sv ----
// Self-checking bench for the SAR conversion control block
`timescale 1ns/1ps
module sar8_conversion_control_tb;
  import sar8_pkg::*;
  logic clk, rstn, converter_on, low_power_track_sel, busy_write_one, partner_conv_go, timer3_overflow;
  logic timer2_overflow, ext_convert_strobe, chip_standby, done_flag_clear, interrupt_enable, sar_compare;
  logic result_ready, conv_in_progress, conv_done_flag, irq, sar_clk_en, result_valid;
  logic [2:0] start_source_sel, channel_select;
  logic [4:0] clock_divide_field;
  logic [1:0] gain_code;
  logic [7:0] level, result_byte;
  analog_ctrl_t analog_ctrl;
  result_t result_data;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  sar8_conversion_control DUT (.*);
  sar8_comparator_model partner (.clk(clk), .analog_ctrl(analog_ctrl), .level(level), .sar_compare(sar_compare));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic fire(input logic [2:0] sel);
    @(posedge clk);
    case (sel)
      3'h0: busy_write_one <= 1'b1;
      3'h1: timer3_overflow <= 1'b1;
      3'h2: ext_convert_strobe <= 1'b1;
      3'h3: timer2_overflow <= 1'b1;
      default: partner_conv_go <= 1'b1;
    endcase
    @(posedge clk);
    {busy_write_one, timer3_overflow, timer2_overflow, partner_conv_go, ext_convert_strobe} <= 5'h00;
  endtask : fire
  task automatic wait_idle(output int n);
    n = 0;
    while (conv_in_progress === 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////////
  task automatic convert(input logic [2:0] sel, input logic [7:0] lvl, input logic lp);
    int n;
    int t;
    t = (lp && sel != 3'h2) ? 13 : 10;
    @(posedge clk);
    start_source_sel <= sel;
    low_power_track_sel <= lp;
    interrupt_enable <= sel[0];
    level <= lvl;
    channel_select <= lvl[2:0];
    done_flag_clear <= 1'b1;
    @(posedge clk);
    done_flag_clear <= 1'b0;
    fire(sel == 3'h0 ? 3'h1 : 3'h0);
    #1 check(conv_in_progress, 1'b0);
    check(irq, 1'b0);
    fire(sel);
    #1 check(conv_in_progress, 1'b1);
    // A repeat of the start while busy must be dropped
    fire(sel);
    wait_idle(n);
    check(n + 2 >= (t - 1) * 5 && n + 2 <= t * 5 + 2, 1'b1);
    @(posedge clk);
    #1 check(conv_done_flag, 1'b1);
    check(irq, interrupt_enable);
    check(result_byte, lvl);
    check(conv_in_progress, 1'b0);
    check(result_data, {lvl[2:0], 2'h0, lvl});
    check(analog_ctrl.channel_onehot, 8'h01 << lvl[2:0]);
    @(posedge clk);
    result_ready <= 1'b1;
    @(posedge clk);
    result_ready <= 1'b0;
  endtask : convert
  task automatic modes;
    for (int g = 0; g < 4; g++) begin
      @(posedge clk);
      gain_code <= g[1:0];
      repeat (2) @(posedge clk);
      #1 check(analog_ctrl.gain_onehot, 4'h1 << g);
    end
    @(posedge clk);
    low_power_track_sel <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(analog_ctrl.track, 1'b1);
    @(posedge clk);
    chip_standby <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(analog_ctrl.track, 1'b0);
    @(posedge clk);
    chip_standby <= 1'b0;
  endtask : modes
  task automatic shutdown;
    @(posedge clk);
    start_source_sel <= 3'h3;
    fire(3'h3);
    repeat (12) @(posedge clk);
    converter_on <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(conv_in_progress, 1'b0);
    check(analog_ctrl.powered, 1'b0);
    fire(3'h3);
    #1 check(conv_in_progress, 1'b0);
    check(result_valid, 1'b0);
    @(posedge clk);
    converter_on <= 1'b1;
    // slower SAR clock of 3.125 MHz for the queue fill, changed on the same edge that turns the converter back on
    clock_divide_field <= 5'h07;
  endtask : shutdown
  task automatic fill;
    int n;
    int w;
    n = 0;
    for (int i = 0; i < 34; i++) begin
      fire(3'h3);
      #1 if (conv_in_progress === 1'b1) n++;
      wait_idle(w);
    end
    check(16'(n), 16'h0020);
    n = 0;
    @(posedge clk);
    result_ready <= 1'b1;
    #1 while (result_valid === 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    check(16'(n), 16'h0020);
    @(posedge clk);
    result_ready <= 1'b0;
  endtask : fill
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {low_power_track_sel, busy_write_one, partner_conv_go, timer3_overflow, timer2_overflow, ext_convert_strobe,
     chip_standby, done_flag_clear, interrupt_enable, result_ready, start_source_sel} = '0;
    // Gain code held away from zero in reset, so only the reset value can read back as 0.5
    gain_code = 2'h3;
    channel_select = 3'h0;
    level = 8'h00;
    converter_on = 1'b1;
    clock_divide_field = 5'h04;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    #1 check(conv_done_flag, 1'b0);
    check(result_byte, 8'h00);
    check(analog_ctrl.gain_onehot, 4'h1);
    @(posedge clk);
    gain_code <= 2'h0;
    convert(3'h0, 8'h00, 1'b0);
    convert(3'h1, 8'hFF, 1'b0);
    convert(3'h2, 8'h80, 1'b0);
    convert(3'h3, 8'h7F, 1'b0);
    convert(3'h4, 8'h5A, 1'b0);
    convert(3'h7, 8'hA6, 1'b0);
    convert(3'h1, 8'h3C, 1'b1);
    convert(3'h2, 8'hC3, 1'b1);
    modes();
    shutdown();
    fill();
    summarize();
  end
endmodule : sar8_conversion_control_tb
bind sar8_conversion_control sar8_conversion_control_monitor mon (.*);
